/* File: drcb_consts.svh */
// Purpose: constants of the second compander parameter block
// Assumes: included by drcb_pkg, drcb_top and the bench
// Notes: offsets are word indices; byte address is four times
`ifndef DRCB_CONSTS_SVH
`define DRCB_CONSTS_SVH
// register indices
`define DRCB_IDX_FXSTS   12'hE01
`define DRCB_IDX_GATE    12'hE8B
`define DRCB_IDX_KNEE    12'hE8C
`define DRCB_IDX_GKNEE   12'hE8D
`define DRCB_IDX_CTRL    12'hE90
`define DRCB_IDX_STAT    12'hE91
`define DRCB_IDX_BUDGET  12'hE92
// reset values
`define DRCB_RST_GATE    16'h0018
`define DRCB_RST_KNEE    16'h0000
`define DRCB_RST_GKNEE   16'h0000
`define DRCB_RST_CTRL    16'h0700
`define DRCB_RST_BUDGET  16'h0180
// admission costs, cycles per sample
`define DRCB_COST_COMP   16'h0080
`define DRCB_COST_MIX    16'h0040
// path layout: 0 left, 1 right, 2..5 mixers
`define DRCB_NPATH       6
`define DRCB_FIRST_MIX   3'h2
// fast-release decay times per 6dB, in ns
`define DRCB_CLK_MHZ     25
`define DRCB_FR_DCY0_NS  725000
`define DRCB_FR_DCY1_NS  1450000
`define DRCB_FR_DCY2_NS  5800000
`define DRCB_FIFO_DEPTH  16
`define DRCB_SAMPLE_W    24
`endif

/* File: drcb_pkg.sv */
// Purpose: types shared by the second compander block
// Assumes: drcb_consts.svh supplies the numbers
// Notes: dB values are two's complement quarter-dB counts
`include "drcb_consts.svh"
package drcb_pkg;
  typedef struct packed {
    logic [4:0] rsv;
    logic [1:0] max_boost;   // compander_b_max_boost
    logic       fr_en;       // compander_b_fast_release_enable
    logic       gko_en;      // compander_b_gate_knee_out_enable
    logic       gate_en;     // compander_b_gate_enable
    logic [3:0] mix_req;     // mixer enable requests
    logic       req_r;       // right channel enable request
    logic       req_l;       // left channel enable request
  } drcb_ctrl_t;
  typedef struct packed {
    logic [3:0] floor_gain;  // compander_b_gate_floor_gain
    logic [1:0] expansion;   // compander_b_gate_expansion
    logic [1:0] fr_thr;      // compander_b_fast_release_threshold
    logic [1:0] fr_decay;    // compander_b_fast_release_decay
    logic [2:0] upper;       // compander_b_upper_slope
    logic [2:0] lower;       // compander_b_lower_slope
  } drcb_gate_t;
  typedef struct packed {
    logic [4:0] rsv;
    logic [5:0] knee_in;     // compander_b_knee_in_level
    logic [4:0] knee_out;    // compander_b_knee_out_level
  } drcb_knee_t;
  typedef struct packed {
    logic [5:0] rsv;
    logic [4:0] gk_in;       // compander_b_gate_knee_in_level
    logic [4:0] gk_out;      // compander_b_gate_knee_out_level
  } drcb_gknee_t;
  typedef struct packed {
    logic                      right;
    logic                      comp;  // set when the compander path handles it
    logic [`DRCB_SAMPLE_W-1:0] data;
  } drcb_sample_t;
  typedef struct packed {
    logic [9:0] max_boost_q;
    logic [9:0] floor_q;
    logic [9:0] fr_thr_q;
    logic [9:0] knee_in_q;
    logic [9:0] knee_out_q;
    logic [9:0] gate_in_q;
    logic [9:0] gate_out_q;
    logic [1:0] exp_shift;   // slope is 2^exp_shift
    logic [2:0] hi_shift;    // slope is 2^-hi_shift
    logic       hi_zero;
    logic [2:0] lo_shift;
    logic       lo_zero;
    logic       gate_on;
    logic       gate_out_on;
    logic       fr_on;
    logic       fr_tick;
  } drcb_cfg_t;
endpackage

/* File: drcb_fifo.sv */
// Purpose: sample FIFO with a registered read port
// Assumes: one clock, synchronous reset
// Notes: the output register holds one sample beyond DEPTH
`timescale 1ns/1ps
`default_nettype none
module drcb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // storage words
    logic [AW-1:0]           wp;   // write pointer
    logic [AW-1:0]           rp;   // read pointer
    logic [AW:0]             cnt;  // words held in storage
    logic                    ov;   // output register full
    logic [W-1:0]            od;   // output register
  } drcb_fifo_st_t;
  drcb_fifo_st_t s, next_s;
  logic push;
  logic load;
  // full only when storage holds DEPTH words
  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = s.ov;
  assign out_data  = s.od;
  // next-state logic
  always_comb begin
    next_s = s;
    push   = in_valid && in_ready;
    load   = (s.cnt != '0) && (!s.ov || out_ready);
    if (out_ready && s.ov) begin
      next_s.ov = 1'b0;
    end
    if (load) begin  // refill the output register from the head
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = s.rp + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = s.wp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(load);
  end
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // drcb_fifo
`default_nettype wire

/* File: drcb_admit.sv */
// Purpose: one-request clock budget check
// Assumes: request stands one cycle
// Notes: answer comes one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module drcb_admit (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        req_valid,
  input  wire logic [15:0] req_cost,
  input  wire logic [15:0] load,
  input  wire logic [15:0] budget,
  output logic             done,
  output logic             grant
);
  typedef struct packed {
    logic done;   // answer strobe
    logic grant;  // request fits
  } drcb_admit_st_t;
  drcb_admit_st_t s, next_s;
  assign done  = s.done;
  assign grant = s.grant;
  // running load plus new path against the budget
  always_comb begin
    next_s.done  = req_valid;
    next_s.grant = req_valid && (({1'b0, load} + {1'b0, req_cost}) <= {1'b0, budget});
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // drcb_admit
`default_nettype wire

/* File: drcb_top.sv */
// Purpose: second stereo compander parameters, clock budget admission, sample path
// Assumes: APB and stream partner on clk; srst synchronous
// Notes: dB outputs are two's complement quarter-dB counts
// Functional notes
// (RULE_01) Max boost code picks 12/18/24/36dB, reset 36dB
// (RULE_02) Gate floor gain -36dB plus 6dB per step
// (RULE_03) Gate expansion slope 1, 2, 4 or 8
// (RULE_04) Fast release threshold 12 to 30dB crest
// (RULE_05) Fast release decay 0.725, 1.45, 5.8ms per 6dB
// (RULE_06) Upper slope 1 down to 1/16 or 0
// (RULE_07) Lower slope 1 down to 1/8 or 0
// (RULE_08) Knee in/out levels in -0.75dB steps
// (RULE_09) Gate knee input level, used only with gate
// (RULE_10) Gate knee output level, used only when enabled
// (RULE_11) Check clock budget before admitting any path
// (RULE_12) Refused path stays off, underclock error raised
// (RULE_13) Refusal never disturbs paths already running
// (RULE_14) Underclock error on pin and as interrupt source
// (RULE_15) Effects status shows paths really enabled
// (RULE_16) Mixer status bits show successful enables
// (RULE_17) Status bit 7 right, bit 6 left channel
// (RULE_18) Gate enable bit, reset off, qualifies gate settings
// (RULE_19) Software must not write reserved codes
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "drcb_consts.svh"
module drcb_top #(
  parameter int FR_DCY0_CYC = (`DRCB_FR_DCY0_NS * `DRCB_CLK_MHZ) / 1000,
  parameter int FR_DCY1_CYC = (`DRCB_FR_DCY1_NS * `DRCB_CLK_MHZ) / 1000,
  parameter int FR_DCY2_CYC = (`DRCB_FR_DCY2_NS * `DRCB_CLK_MHZ) / 1000
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [15:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire drcb_pkg::drcb_sample_t in_sample,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output drcb_pkg::drcb_sample_t     out_sample,
  input  wire logic [11:0]           other_fx_status,
  output drcb_pkg::drcb_cfg_t        gain_cfg,
  output logic [1:0]                 comp_active,
  output logic [3:0]                 mixer_active,
  output logic                       underclock_err,
  output logic                       underclock_pulse
);
  import drcb_pkg::*;

  typedef struct packed {
    logic                    rdy;      // APB answer strobe
    logic                    err;      // APB error for the answer
    logic [31:0]             rdata;    // APB read data
    drcb_ctrl_t              ctrl;     // software requests and enables
    drcb_gate_t              gate;     // gate and slope settings
    drcb_knee_t              knee;     // compressor knee
    drcb_gknee_t             gknee;    // gate knee
    logic [15:0]             budget;   // cycles per sample available
    logic [`DRCB_NPATH-1:0]  active;   // admitted paths
    logic [`DRCB_NPATH-1:0]  pending;  // requests awaiting the check
    logic                    busy;     // a check is in flight
    logic [2:0]              cur;      // path under check
    logic                    uc_err;   // sticky underclock error
    logic                    uc_pulse; // one-cycle underclock event
    logic [17:0]             fr_cnt;   // decay period counter
    drcb_cfg_t               cfg;      // decoded settings
    logic                    ov;       // output register full
    drcb_sample_t            od;       // output sample
  } drcb_st_t;

  drcb_st_t     s, next_s;
  logic [11:0]  idx;        // word index of the access
  logic         hit;        // mapped and aligned
  logic         wr_go;      // write takes effect this edge
  logic [15:0]  rd_val;     // read mux
  logic [15:0]  load;       // sum of admitted costs
  logic         adm_req;    // issue a check
  logic         adm_done;
  logic         adm_grant;
  logic [2:0]   pick;       // lowest pending path
  logic [17:0]  fr_period;  // decay period minus one
  logic         f_valid;    // fifo head
  logic         f_ready;
  drcb_sample_t f_data;
  logic [`DRCB_NPATH-1:0] req_vec;

  // word-aligned map check, shared by read and write
  function automatic logic reg_hit(input logic [11:0] i, input logic [1:0] lo);
    reg_hit = (lo == 2'h0) &&
              (i == `DRCB_IDX_FXSTS || i == `DRCB_IDX_GATE || i == `DRCB_IDX_KNEE ||
               i == `DRCB_IDX_GKNEE || i == `DRCB_IDX_CTRL || i == `DRCB_IDX_STAT ||
               i == `DRCB_IDX_BUDGET);
  endfunction

  // clock cycles a path consumes
  function automatic logic [15:0] path_cost(input logic [2:0] p);
    path_cost = (p < `DRCB_FIRST_MIX) ? `DRCB_COST_COMP : `DRCB_COST_MIX;
  endfunction

  // reserved codes fold to a neighbour [RULE_19]
  function automatic logic [9:0] boost_q(input logic [1:0] c);
    logic [9:0] q;
    q = 10'h000;
    unique case (c)
      2'h0: q = 10'h030;  // 12dB [RULE_01]
      2'h1: q = 10'h048;  // 18dB
      2'h2: q = 10'h060;  // 24dB
      2'h3: q = 10'h090;  // 36dB
    endcase
    return q;
  endfunction

  assign idx     = paddr[13:2];
  assign hit     = reg_hit(idx, paddr[1:0]) && (paddr[15:14] == 2'h0);
  assign wr_go   = psel && penable && s.rdy && pwrite && hit;
  assign pready  = s.rdy;
  assign pslverr = s.rdy && s.err;
  assign prdata  = s.rdata;
  assign comp_active      = s.active[1:0];
  assign mixer_active     = s.active[`DRCB_NPATH-1:2];
  assign underclock_err   = s.uc_err;    // routed to a GPIO select and the IRQ block [RULE_14]
  assign underclock_pulse = s.uc_pulse;  // edge for an interrupt controller [RULE_14]
  assign gain_cfg   = s.cfg;
  assign out_valid  = s.ov;
  assign out_sample = s.od;
  assign f_ready    = !s.ov || out_ready;
  assign req_vec    = {s.ctrl.mix_req, s.ctrl.req_r, s.ctrl.req_l};

  // load of running paths; refused paths add nothing [RULE_11]
  always_comb begin
    load = 16'h0000;
    pick = 3'h0;
    for (int p = `DRCB_NPATH - 1; p >= 0; p--) begin
      if (s.active[p]) begin
        load = load + path_cost(3'(p));
      end
      if (s.pending[p]) begin
        pick = 3'(p);
      end
    end
  end

  // decay period per code; reserved 11 is slowest [RULE_05]
  always_comb begin
    fr_period = 18'(FR_DCY2_CYC - 1);
    unique case (s.gate.fr_decay)
      2'h0:    fr_period = 18'(FR_DCY0_CYC - 1);
      2'h1:    fr_period = 18'(FR_DCY1_CYC - 1);
      default: fr_period = 18'(FR_DCY2_CYC - 1);
    endcase
  end

  // register read mux
  always_comb begin
    rd_val = 16'h0000;
    unique case (idx)
      // this block owns bits 7:6 of the status field [RULE_15] [RULE_17]
      `DRCB_IDX_FXSTS: rd_val = {other_fx_status[11:8], s.active[1], s.active[0],
                                 other_fx_status[5:0], 4'h0};
      `DRCB_IDX_GATE:   rd_val = s.gate;
      `DRCB_IDX_KNEE:   rd_val = s.knee;
      `DRCB_IDX_GKNEE:  rd_val = s.gknee;
      `DRCB_IDX_CTRL:   rd_val = s.ctrl;
      `DRCB_IDX_STAT:   rd_val = {10'h000, s.active[`DRCB_NPATH-1:2], s.busy, s.uc_err}; // [RULE_16]
      `DRCB_IDX_BUDGET: rd_val = s.budget;
      default:          rd_val = 16'h0000;
    endcase
  end

  assign adm_req = !s.busy && (s.pending != '0);

  drcb_admit u_admit (
    .clk       (clk),
    .srst      (srst),
    .req_valid (adm_req),
    .req_cost  (path_cost(pick)),
    .load      (load),
    .budget    (s.budget),
    .done      (adm_done),
    .grant     (adm_grant)
  );

  drcb_fifo #(
    .W     ($bits(drcb_sample_t)),
    .DEPTH (`DRCB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_sample),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // next-state logic for the whole block
  always_comb begin
    drcb_ctrl_t nc;
    nc     = drcb_ctrl_t'(pwdata[15:0]);
    next_s = s;
    next_s.uc_pulse = 1'b0;
    // APB: one wait state, the answer stands for one cycle
    if (psel && penable && !s.rdy) begin
      next_s.rdy   = 1'b1;
      next_s.err   = !hit;
      next_s.rdata = {16'h0000, rd_val};
    end else begin
      next_s.rdy = 1'b0;
    end
    // admission result lands first so a same-cycle write can still drop it
    if (adm_done) begin
      next_s.busy = 1'b0;
      if (adm_grant && s.pending[s.cur]) begin
        next_s.active[s.cur] = 1'b1;   // [RULE_11]
      end else if (s.pending[s.cur]) begin
        next_s.uc_err   = 1'b1;        // path stays off [RULE_12]
        next_s.uc_pulse = 1'b1;
      end
      next_s.pending[s.cur] = 1'b0;
    end
    if (adm_req) begin
      next_s.busy = 1'b1;
      next_s.cur  = pick;
    end
    if (wr_go) begin
      unique case (idx)
        `DRCB_IDX_GATE:   next_s.gate   = drcb_gate_t'(pwdata[15:0]);
        `DRCB_IDX_KNEE:   next_s.knee   = {5'h00, pwdata[10:0]};
        `DRCB_IDX_GKNEE:  next_s.gknee  = {6'h00, pwdata[9:0]};
        `DRCB_IDX_BUDGET: next_s.budget = pwdata[15:0];
        `DRCB_IDX_CTRL: begin
          next_s.ctrl     = nc;
          next_s.ctrl.rsv = 5'h00;
          // only new requests are checked; running paths stay [RULE_13]
          for (int p = 0; p < `DRCB_NPATH; p++) begin
            if (!nc[p]) begin
              next_s.active[p]  = 1'b0;
              next_s.pending[p] = 1'b0;
            end else if (!next_s.active[p]) begin
              next_s.pending[p] = 1'b1;
            end
          end
        end
        `DRCB_IDX_STAT: begin
          // write one clears; a same-cycle refusal wins [RULE_14]
          if (pwdata[0] && !(adm_done && !adm_grant && s.pending[s.cur])) begin
            next_s.uc_err = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // fast-release decay tick while a channel runs
    next_s.cfg.fr_tick = 1'b0;
    if (!s.ctrl.fr_en || (s.active[1:0] == 2'h0)) begin
      next_s.fr_cnt = 18'h00000;
    end else if (s.fr_cnt >= fr_period) begin
      next_s.fr_cnt      = 18'h00000;
      next_s.cfg.fr_tick = 1'b1;       // one 6dB step of release [RULE_05]
    end else begin
      next_s.fr_cnt = s.fr_cnt + 18'h00001;
    end
    // decoded settings for the gain engine
    next_s.cfg.max_boost_q = boost_q(s.ctrl.max_boost); // [RULE_01]
    next_s.cfg.floor_q = 10'h370 + 10'(s.gate.floor_gain > 4'hC ? 4'hC : s.gate.floor_gain)
                         * 10'h018; // [RULE_02]
    next_s.cfg.exp_shift = s.gate.expansion; // [RULE_03]
    next_s.cfg.fr_thr_q  = 10'h030 + 10'(s.gate.fr_thr) * 10'h018; // [RULE_04]
    next_s.cfg.fr_on     = s.ctrl.fr_en;
    next_s.cfg.hi_zero   = (s.gate.upper >= 3'h5); // [RULE_06]
    next_s.cfg.hi_shift  = (s.gate.upper >= 3'h5) ? 3'h0 : s.gate.upper; // [RULE_06]
    next_s.cfg.lo_zero   = (s.gate.lower >= 3'h4); // [RULE_07]
    next_s.cfg.lo_shift  = (s.gate.lower >= 3'h4) ? 3'h0 : s.gate.lower; // [RULE_07]
    next_s.cfg.knee_in_q = 10'h000 - 10'(s.knee.knee_in > 6'h3C ? 6'h3C : s.knee.knee_in)
                           * 10'h003; // [RULE_08]
    next_s.cfg.knee_out_q = 10'h000 - 10'(s.knee.knee_out > 5'h1E ? 5'h1E : s.knee.knee_out)
                            * 10'h003; // [RULE_08]
    next_s.cfg.gate_on   = s.ctrl.gate_en; // [RULE_18]
    // gate knee input counts only with the gate
    next_s.cfg.gate_in_q = s.ctrl.gate_en ?
                           10'h370 - 10'(s.gknee.gk_in) * 10'h006 : 10'h000; // [RULE_09]
    next_s.cfg.gate_out_on = s.ctrl.gko_en;
    next_s.cfg.gate_out_q  = s.ctrl.gko_en ?
                             10'h388 - 10'(s.gknee.gk_out) * 10'h006 : 10'h000; // [RULE_10]
    // floor gain and expansion need the gate
    if (!s.ctrl.gate_en) begin
      next_s.cfg.floor_q   = 10'h000; // [RULE_18]
      next_s.cfg.exp_shift = 2'h0;
    end
    // sample path: mark samples of admitted channels
    if (out_ready && s.ov) begin
      next_s.ov = 1'b0;
    end
    if (f_valid && f_ready) begin
      next_s.ov      = 1'b1;
      next_s.od      = f_data;
      next_s.od.comp = f_data.right ? s.active[1] : s.active[0];
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s        <= '0;
      s.ctrl   <= `DRCB_RST_CTRL;
      s.gate   <= `DRCB_RST_GATE;
      s.knee   <= `DRCB_RST_KNEE;
      s.gknee  <= `DRCB_RST_GKNEE;
      s.budget <= `DRCB_RST_BUDGET;
    end else begin
      s <= next_s;
    end
  end
endmodule // drcb_top
`default_nettype wire

/* File: drcb_top_sva.sv */
// Purpose: port checker for drcb_top
// Assumes: one clock, srst synchronous
// Notes: attached by bind from the bench
`timescale 1ns/1ps
`default_nettype none
module drcb_top_sva (
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   out_valid,
  input wire logic                   out_ready,
  input wire drcb_pkg::drcb_sample_t out_sample,
  input wire logic [1:0]             comp_active,
  input wire logic [3:0]             mixer_active,
  input wire logic                   underclock_err,
  input wire logic                   underclock_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // apb: one wait state, one-cycle answer
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && !pready; endsequence
  a_apb_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready late");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_sticky: assert property (underclock_err && !(pready && pwrite) |=> underclock_err)
    else $error("error flag dropped");
  a_pulse_err: assert property (underclock_pulse |-> underclock_err)
    else $error("pulse without error flag");
  a_pulse_single: assert property (underclock_pulse |=> !underclock_pulse)
    else $error("refusal pulse too long");
  // a refusal must not touch running paths
  a_refuse_keeps: assert property (underclock_pulse |-> $stable(comp_active) && $stable(mixer_active))
    else $error("refusal changed paths");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("output sample not held");
endmodule // drcb_top_sva
`default_nettype wire

/* File: drcb_fabric.sv */
// Purpose: mixing fabric model, source and sink
// Assumes: drives right after rising edges
// Notes: sends 20 samples while go; stall holds output ready low
`timescale 1ns/1ps
`default_nettype none
module drcb_fabric (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   go,
  input  wire logic                   stall,
  output logic                        in_valid,
  input  wire logic                   in_ready,
  output drcb_pkg::drcb_sample_t      in_sample,
  input  wire logic                   out_valid,
  output logic                        out_ready,
  input  wire drcb_pkg::drcb_sample_t out_sample
);
  import drcb_pkg::*;
  int           ns = 0;  // samples accepted
  int           nrx = 0; // samples received
  int           k;
  drcb_sample_t rx [32]; // received log, read by the bench
  initial begin
    in_valid = 1'b0;
    out_ready = 1'b0;
    in_sample = '0;
  end
  // source holds a sample until taken; idle bus is scrambled, not kept
  always @(posedge clk) begin
    if (srst) begin
      in_valid <= 1'b0;
      ns <= 0;
      nrx <= 0;
    end else begin
      k = ns + int'(in_valid && in_ready);
      ns <= k;
      if (go && k < 20) begin
        in_valid <= 1'b1;
        in_sample <= {k[0], 1'b1, 24'h5A0000 + 24'(k)};
      end else begin
        in_valid <= 1'b0;
        in_sample <= ~in_sample;
      end
      // sink takes every other cycle, so it stalls even when free
      out_ready <= !stall && !out_ready;
      if (out_valid && out_ready) begin
        rx[nrx] <= out_sample;
        nrx <= nrx + 1;
      end
    end
  end
endmodule // drcb_fabric
`default_nettype wire

/* File: dynamic_range_ctrl_second_bench.sv */
// Purpose: self-checking bench for drcb_top
// Assumes: apb master on clk, fabric model on the sample ports
// Notes: decay counts shortened to 8/16/32 cycles
`timescale 1ns/1ps
`default_nettype none
`include "drcb_consts.svh"
module dynamic_range_ctrl_second_bench;
  import drcb_pkg::*;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, stall = 1;
  logic        pready, pslverr, in_valid, in_ready, out_valid, out_ready, err;
  logic        underclock_err, underclock_pulse;
  logic [15:0] paddr = '0, rd;
  logic [31:0] pwdata = '0, prdata;
  logic [11:0] other_fx_status = 12'h93F;
  logic [1:0]  comp_active;
  logic [3:0]  mixer_active;
  drcb_sample_t in_sample, out_sample;
  drcb_cfg_t    gain_cfg;
  int          miscompares = 0, samples_checked = 0, n, m;
  drcb_top #(.FR_DCY0_CYC(8), .FR_DCY1_CYC(16), .FR_DCY2_CYC(32)) i_dut (.clk, .srst, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr, .in_valid, .in_ready,
    .in_sample, .out_valid, .out_ready, .out_sample, .other_fx_status, .gain_cfg,
    .comp_active, .mixer_active, .underclock_err, .underclock_pulse);
  drcb_fabric i_fab (.clk, .srst, .go, .stall, .in_valid, .in_ready, .in_sample,
    .out_valid, .out_ready, .out_sample);
  always #20 clk = ~clk;
  // apb transfer; pready sampled at the edge
  task automatic apb(input logic [11:0] idx, input logic w, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) miscompares++;
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  function automatic logic [31:0] q(input int x);
    return {22'h0, x[9:0]};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    apb(`DRCB_IDX_GATE, 0, 0);
    chk("gate reset", 32'h0018, rd);
    apb(`DRCB_IDX_CTRL, 0, 0);
    chk("ctrl reset", 32'h0700, rd);
    chk("boost reset", q(144), gain_cfg.max_boost_q);
    apb(12'hE8F, 0, 0);
    chk("unmapped", 32'h10000, {err, rd});
    // codes 0 to 3 of boost, floor, expansion, threshold, slopes
    for (int k = 0; k < 4; k++) begin
      apb(`DRCB_IDX_CTRL, 1, 16'(32'h1C0 | k << 9));
      apb(`DRCB_IDX_GATE, 1, 16'(k << 12 | k << 10 | k << 8 | k << 3 | k));
      repeat (2) @(posedge clk);
      chk("boost", q(k == 3 ? 144 : 48 + 24 * k), gain_cfg.max_boost_q);
      chk("floor", q(24 * k - 144), gain_cfg.floor_q);
      chk("expansion", k, gain_cfg.exp_shift);
      chk("threshold", q(48 + 24 * k), gain_cfg.fr_thr_q);
      chk("slopes", k << 5 | k << 1, {gain_cfg.hi_shift, gain_cfg.hi_zero,
        gain_cfg.lo_shift, gain_cfg.lo_zero});
    end
    apb(`DRCB_IDX_GATE, 1, 16'hC02C);
    apb(`DRCB_IDX_KNEE, 1, 16'h079E);
    apb(`DRCB_IDX_GKNEE, 1, 16'h03FF);
    repeat (2) @(posedge clk);
    chk("floor top", q(144), gain_cfg.floor_q);
    chk("zero slopes", 2'b11, {gain_cfg.hi_zero, gain_cfg.lo_zero});
    chk("knee in", q(-180), gain_cfg.knee_in_q);
    chk("knee out", q(-90), gain_cfg.knee_out_q);
    chk("gate in", q(-330), gain_cfg.gate_in_q);
    chk("gate out", q(-306), gain_cfg.gate_out_q);
    apb(`DRCB_IDX_CTRL, 1, 16'h0701); // left path runs decay
    repeat (2) @(posedge clk);
    chk("gate off", 0, {gain_cfg.gate_on, gain_cfg.gate_in_q, gain_cfg.gate_out_q});
    // decay tick spacing per code
    for (int c = 0; c < 3; c++) begin
      apb(`DRCB_IDX_GATE, 1, 16'(c << 6));
      repeat (2) begin
        m = 0;
        do begin
          @(posedge clk);
          m++;
        end while (gain_cfg.fr_tick !== 1'b1 && m < 99);
      end
      chk("decay ticks", 8 << c, m);
    end
    // six requests against a 0x180 budget: two mixers refused
    apb(`DRCB_IDX_CTRL, 1, 16'h073F);
    repeat (16) @(posedge clk);
    chk("paths", 6'b001111, {mixer_active, comp_active});
    chk("error pin", 1, underclock_err);
    apb(`DRCB_IDX_FXSTS, 0, 0);
    chk("fx status", 32'h9FF0, rd);
    apb(`DRCB_IDX_STAT, 0, 0);
    chk("stat", 32'h000D, rd & 16'h003D);
    apb(`DRCB_IDX_STAT, 1, 16'h0001);
    apb(`DRCB_IDX_BUDGET, 1, 16'h0080);
    apb(`DRCB_IDX_CTRL, 1, 16'h0701);
    chk("cleared", 0, underclock_err);
    apb(`DRCB_IDX_CTRL, 1, 16'h0703);
    repeat (8) @(posedge clk);
    chk("retry refused", 6'b000001, {mixer_active, comp_active});
    chk("error again", 1, underclock_err);
    apb(`DRCB_IDX_FXSTS, 0, 0);
    chk("fx status", 32'h97F0, rd);
    // fill against a stalled sink, then drain
    go <= 1'b1;
    repeat (40) @(posedge clk);
    chk("full", 0, in_ready);
    stall <= 1'b0;
    repeat (100) @(posedge clk);
    chk("received", 20, i_fab.nrx);
    for (int k = 0; k < 20; k++)
      chk("sample", {k[0], !k[0], 24'h5A0000 + 24'(k)}, i_fab.rx[k]);
    print_verdict;
  end
endmodule // dynamic_range_ctrl_second_bench
bind drcb_top drcb_top_sva i_sva (.clk, .srst, .psel, .penable, .pwrite, .pready, .pslverr,
  .out_valid, .out_ready, .out_sample, .comp_active, .mixer_active, .underclock_err,
  .underclock_pulse);
`default_nettype wire
